// ===== nip_ctrl.sv
// Nested interrupt priority control with AHB-Lite register slave
`timescale 1ns/100ps
module nip_ctrl
  import nip_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic instr_valid,
  input wire nip_op_t instr_op,
  input wire logic [7:0] stack_cond,
  input wire logic alu_flags_we,
  input wire logic [3:0] alu_flags,
  output logic [7:0] condition_code_reg,
  output logic branch_done,
  output logic branch_taken,
  output logic trap_nmi,
  output logic ctx_restore,
  output logic [31:0] vec_priority,
  output logic [7:0] external_edge_select,
  output logic top_level_edge_select,
  output logic top_level_irq_enable
);

  // ****************************************
  // Declarations
  // ****************************************
  nip_bus_t bus_st_ff, nxt_bus_st;
  logic wr_pend_ff, nxt_wr_pend;
  logic [7:0] wr_idx_ff, nxt_wr_idx;
  logic [7:0] rd_idx_ff, nxt_rd_idx;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic hreadyout_ff, nxt_hreadyout;
  logic [7:0] ext_edge_ff, nxt_ext_edge;
  logic [1:0] top_ctrl_ff, nxt_top_ctrl;
  logic [7:0] cond_ff, nxt_cond;
  logic br_done_ff, nxt_br_done;
  logic br_taken_ff, nxt_br_taken;
  logic trap_ff, nxt_trap;
  logic restore_ff, nxt_restore;
  logic [3:0] bank_wr;
  logic accept;
  logic masked;
  logic [7:0] rd_byte;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Reads take one wait state so that a write in the preceding data phase
  // is already visible; writes complete with no wait.
  assign accept = hsel && htrans[1] && hready;

  always_comb begin
    unique case (rd_idx_ff)
      IDX_PRIO_BANK0: rd_byte = vec_priority[7:0];
      IDX_PRIO_BANK1: rd_byte = vec_priority[15:8];
      IDX_PRIO_BANK2: rd_byte = vec_priority[23:16];
      IDX_PRIO_BANK3: rd_byte = vec_priority[31:24];
      IDX_EXT_EDGE: rd_byte = ext_edge_ff;
      IDX_TOP_CTRL: rd_byte = {6'h00, top_ctrl_ff};
      IDX_COND_STATUS: rd_byte = cond_ff;
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    nxt_bus_st = bus_st_ff;
    nxt_wr_pend = accept && hwrite;
    nxt_wr_idx = haddr[9:2];
    nxt_rd_idx = rd_idx_ff;
    nxt_hrdata = hrdata_ff;
    nxt_hreadyout = 1'b1;
    unique case (bus_st_ff)
      NIP_BUS_IDLE: begin
        if (accept && !hwrite) begin
          nxt_bus_st = NIP_BUS_RD_WAIT;
          nxt_rd_idx = haddr[9:2];
          nxt_hreadyout = 1'b0;
        end
      end
      NIP_BUS_RD_WAIT: begin
        nxt_bus_st = NIP_BUS_IDLE;
        nxt_hrdata = {24'h000000, rd_byte};
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bus_st_ff <= NIP_BUS_IDLE;
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 8'h00;
      rd_idx_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
    end else begin
      bus_st_ff <= nxt_bus_st;
      wr_pend_ff <= nxt_wr_pend;
      wr_idx_ff <= nxt_wr_idx;
      rd_idx_ff <= nxt_rd_idx;
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= nxt_hreadyout;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;

  // ****************************************
  // Priority and external control registers
  // ****************************************
  assign bank_wr[0] = wr_pend_ff && (wr_idx_ff == IDX_PRIO_BANK0);
  assign bank_wr[1] = wr_pend_ff && (wr_idx_ff == IDX_PRIO_BANK1);
  assign bank_wr[2] = wr_pend_ff && (wr_idx_ff == IDX_PRIO_BANK2);
  assign bank_wr[3] = wr_pend_ff && (wr_idx_ff == IDX_PRIO_BANK3);

  nip_prio_bank u_prio_bank (
    .core_clk(core_clk),
    .nrst(nrst),
    .bank_wr(bank_wr),
    .wr_data(hwdata[7:0]),
    .prio_pairs(vec_priority)
  );

  always_comb begin
    nxt_ext_edge = ext_edge_ff;
    nxt_top_ctrl = top_ctrl_ff;
    if (wr_pend_ff && (wr_idx_ff == IDX_EXT_EDGE)) begin
      nxt_ext_edge = hwdata[7:0];
    end
    if (wr_pend_ff && (wr_idx_ff == IDX_TOP_CTRL)) begin
      nxt_top_ctrl = hwdata[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ext_edge_ff <= EXT_EDGE_RST;
      top_ctrl_ff <= TOP_CTRL_RST;
    end else begin
      ext_edge_ff <= nxt_ext_edge;
      top_ctrl_ff <= nxt_top_ctrl;
    end
  end

  assign external_edge_select = ext_edge_ff;
  assign top_level_edge_select = top_ctrl_ff[TOP_EDGE_SEL_POS];
  assign top_level_irq_enable = top_ctrl_ff[TOP_IRQ_EN_POS];

  // ****************************************
  // Condition code and instruction effects
  // ****************************************
  assign masked = {cond_ff[COND_I1_POS], cond_ff[COND_I0_POS]} == SOFT_PRIO_LVL3;

  always_comb begin
    nxt_cond = cond_ff;
    nxt_br_done = 1'b0;
    nxt_br_taken = 1'b0;
    nxt_trap = 1'b0;
    nxt_restore = 1'b0;
    // ALU flag updates first, so a stack restore in the same cycle wins
    if (alu_flags_we) begin
      nxt_cond[COND_H_POS] = alu_flags[3];
      nxt_cond[COND_N_POS] = alu_flags[2];
      nxt_cond[COND_Z_POS] = alu_flags[1];
      nxt_cond[COND_C_POS] = alu_flags[0];
    end
    // Without an instruction the priority bits hold their level
    if (instr_valid) begin
      unique case (instr_op)
        NIP_OP_IRQ_EN: begin
          {nxt_cond[COND_I1_POS], nxt_cond[COND_I0_POS]} = SOFT_PRIO_LVL0;
        end
        NIP_OP_HALT, NIP_OP_WAIT_IRQ: begin
          {nxt_cond[COND_I1_POS], nxt_cond[COND_I0_POS]} = SOFT_PRIO_LVL0;
        end
        NIP_OP_IRQ_DIS: begin
          {nxt_cond[COND_I1_POS], nxt_cond[COND_I0_POS]} = SOFT_PRIO_LVL3;
        end
        NIP_OP_TRAP: begin
          // Trap is not maskable: it is raised whatever the level
          nxt_trap = 1'b1;
          {nxt_cond[COND_I1_POS], nxt_cond[COND_I0_POS]} = SOFT_PRIO_LVL3;
        end
        NIP_OP_POP_FLAGS: begin
          nxt_cond = stack_cond | COND_FIXED_ONES;
        end
        NIP_OP_IRQ_RET: begin
          nxt_cond = stack_cond | COND_FIXED_ONES;
          nxt_restore = 1'b1;
        end
        NIP_OP_BR_MASKED: begin
          nxt_br_done = 1'b1;
          nxt_br_taken = masked;
        end
        NIP_OP_BR_UNMASKED: begin
          nxt_br_done = 1'b1;
          nxt_br_taken = !masked;
        end
        NIP_OP_NONE: begin
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cond_ff <= COND_RST;
      br_done_ff <= 1'b0;
      br_taken_ff <= 1'b0;
      trap_ff <= 1'b0;
      restore_ff <= 1'b0;
    end else begin
      cond_ff <= nxt_cond;
      br_done_ff <= nxt_br_done;
      br_taken_ff <= nxt_br_taken;
      trap_ff <= nxt_trap;
      restore_ff <= nxt_restore;
    end
  end

  assign condition_code_reg = cond_ff;
  assign branch_done = br_done_ff;
  assign branch_taken = br_taken_ff;
  assign trap_nmi = trap_ff;
  assign ctx_restore = restore_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  property p_irq_en;
    instr_valid && instr_op == NIP_OP_IRQ_EN |=>
      {condition_code_reg[COND_I1_POS], condition_code_reg[COND_I0_POS]} == 2'h2;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("enable did not give 10");

  property p_irq_dis;
    instr_valid && instr_op == NIP_OP_IRQ_DIS |=>
      {condition_code_reg[COND_I1_POS], condition_code_reg[COND_I0_POS]} == 2'h3;
  endproperty
  a_irq_dis: assert property (p_irq_dis) else $error("disable did not give 11");

  // A second instruction right behind the branch may legally raise done again
  property p_branch;
    instr_valid && (instr_op == NIP_OP_BR_MASKED || instr_op == NIP_OP_BR_UNMASKED) |=>
      branch_done && (branch_taken == ($past(instr_op == NIP_OP_BR_MASKED) ==
      ({$past(condition_code_reg[COND_I1_POS]), $past(condition_code_reg[COND_I0_POS])}
      == 2'h3)))
      ##1 (!branch_done || $past(instr_valid));
  endproperty
  a_branch: assert property (p_branch) else $error("branch decision wrong");

  property p_pop;
    instr_valid && instr_op == NIP_OP_POP_FLAGS |=>
      condition_code_reg == ($past(stack_cond) | 8'hC0);
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not restore flags");

  property p_persist;
    !instr_valid |=>
      $stable({condition_code_reg[COND_I1_POS], condition_code_reg[COND_I0_POS]});
  endproperty
  a_persist: assert property (p_persist) else $error("priority changed on its own");

  property p_halt_wait;
    instr_valid && (instr_op == NIP_OP_HALT || instr_op == NIP_OP_WAIT_IRQ) |=>
      {condition_code_reg[COND_I1_POS], condition_code_reg[COND_I0_POS]} == 2'h2;
  endproperty
  a_halt_wait: assert property (p_halt_wait) else $error("halt or wait did not give 10");

  property p_ext_reset;
    $rose(nrst) |-> external_edge_select == 8'h00 && !top_level_edge_select
      && !top_level_irq_enable;
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("control regs not zero");

  property p_trap;
    instr_valid && instr_op == NIP_OP_TRAP |=> trap_nmi && !ctx_restore;
  endproperty
  a_trap: assert property (p_trap) else $error("trap raised no request");

  property p_irq_return_instr;
    instr_valid && instr_op == NIP_OP_IRQ_RET |=> ctx_restore
      && condition_code_reg == ($past(stack_cond) | 8'hC0);
  endproperty
  a_irq_return_instr: assert property (p_irq_return_instr) else $error("return did not restore");

  property p_rd_wait;
    accept && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

  c_branch_taken: cover property (branch_done && branch_taken);
  c_irq_return_instr: cover property (ctx_restore);
  c_wr_then_rd: cover property (wr_pend_ff ##1 bus_st_ff == NIP_BUS_RD_WAIT);

endmodule // nip_ctrl

// ===== nip_pkg.sv
// Package with constants and types of the nested interrupt priority block
// Function
// - Interrupt-enable instruction loads 10 into the software priority bits.
// - Interrupt-disable instruction loads 11 into the software priority bits.
// - Branch-if-masked jumps only at 11; branch-if-unmasked jumps on any other value.
// - Pop-flags instruction restores the condition code register from the stack, with bits 7 and 6 forced to one.
// - Priority changed by these instructions persists until return, trap, halt, wait-for-interrupt or another of them.
// - Halt and wait-for-interrupt both set the software priority bits to 10.
// - Implemented vector priority pairs reset to 11; external control registers reset to zero.
package nip_pkg;

  // ****************************************
  // Register indexes (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IDX_PRIO_BANK0 = 8'h25;
  localparam logic [7:0] IDX_PRIO_BANK1 = 8'h26;
  localparam logic [7:0] IDX_PRIO_BANK2 = 8'h27;
  localparam logic [7:0] IDX_PRIO_BANK3 = 8'h28;
  localparam logic [7:0] IDX_EXT_EDGE = 8'h29;
  localparam logic [7:0] IDX_TOP_CTRL = 8'h2A;
  localparam logic [7:0] IDX_COND_STATUS = 8'h2B;

  // ****************************************
  // Reset values and field layouts
  // ****************************************
  localparam logic [31:0] PRIO_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] PRIO_IMPL_MASK = 32'h0FFF_FFFC;
  localparam logic [7:0] EXT_EDGE_RST = 8'h00;
  localparam logic [1:0] TOP_CTRL_RST = 2'h0;
  localparam int TOP_IRQ_EN_POS = 0;
  localparam int TOP_EDGE_SEL_POS = 1;
  localparam logic [7:0] COND_RST = 8'hE8;
  localparam logic [7:0] COND_FIXED_ONES = 8'hC0;
  localparam int COND_I1_POS = 5;
  localparam int COND_H_POS = 4;
  localparam int COND_I0_POS = 3;
  localparam int COND_N_POS = 2;
  localparam int COND_Z_POS = 1;
  localparam int COND_C_POS = 0;
  localparam logic [1:0] SOFT_PRIO_LVL0 = 2'h2;
  localparam logic [1:0] SOFT_PRIO_LVL3 = 2'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    NIP_OP_NONE = 4'h0,
    NIP_OP_IRQ_EN = 4'h1,
    NIP_OP_IRQ_DIS = 4'h2,
    NIP_OP_HALT = 4'h3,
    NIP_OP_WAIT_IRQ = 4'h4,
    NIP_OP_POP_FLAGS = 4'h5,
    NIP_OP_IRQ_RET = 4'h6,
    NIP_OP_TRAP = 4'h7,
    NIP_OP_BR_MASKED = 4'h8,
    NIP_OP_BR_UNMASKED = 4'h9
  } nip_op_t;

  typedef enum logic {
    NIP_BUS_IDLE = 1'b0,
    NIP_BUS_RD_WAIT = 1'b1
  } nip_bus_t;

endpackage

// ===== nip_prio_bank.sv
// Per-vector two-bit software priority storage
`timescale 1ns/100ps
module nip_prio_bank
  import nip_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] bank_wr,
  input wire logic [7:0] wr_data,
  output logic [31:0] prio_pairs
);

  // ****************************************
  // One generate entry per priority pair
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < 16; p++) begin : g_pair
      if (PRIO_IMPL_MASK[2*p]) begin : g_impl
        logic [1:0] pair_ff;
        logic [1:0] nxt_pair;
        always_comb begin
          nxt_pair = pair_ff;
          if (bank_wr[p/4]) begin
            nxt_pair = wr_data[2*(p%4) +: 2];
          end
        end
        always_ff @(posedge core_clk) begin
          if (!nrst) begin
            pair_ff <= PRIO_RST[2*p +: 2];
          end else begin
            pair_ff <= nxt_pair;
          end
        end
        assign prio_pairs[2*p +: 2] = pair_ff;
      end else begin : g_fixed
        // Unimplemented pairs read back as level 3 for ever
        assign prio_pairs[2*p +: 2] = PRIO_RST[2*p +: 2];
      end
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  property p_prio_reset;
    @(posedge core_clk) $rose(nrst) |-> prio_pairs == PRIO_RST;
  endproperty
  a_prio_reset: assert property (p_prio_reset) else $error("priority pairs not 11 after reset");

endmodule // nip_prio_bank

// ===== nip_core_model.sv
// Behavioural CPU core that issues instructions to the priority block
`timescale 1ns/100ps
module nip_core_model
  import nip_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic req,
  input wire logic [3:0] req_op,
  input wire logic [7:0] req_cond,
  input wire logic req_we,
  input wire logic [3:0] req_flags,
  output logic instr_valid,
  output nip_op_t instr_op,
  output logic [7:0] stack_cond,
  output logic alu_flags_we,
  output logic [3:0] alu_flags
);
  initial begin
    instr_valid = 1'b0;
    instr_op = NIP_OP_NONE;
    stack_cond = 8'h5A;
    alu_flags_we = 1'b0;
    alu_flags = 4'h0;
  end
  // Stack byte and flags only mean something with the pulse, so scramble them between
  always @(posedge core_clk) begin
    instr_valid <= req & nrst;
    alu_flags_we <= req & req_we;
    instr_op <= nip_op_t'(req_op);
    stack_cond <= req ? req_cond : ~stack_cond;
    alu_flags <= req ? req_flags : ~alu_flags;
  end
endmodule // nip_core_model

// ===== tb.sv
// Self-checking testbench of the nested interrupt priority control
`timescale 1ns/100ps
module tb
  import nip_pkg::*;
;
  logic core_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, req = 1'b0, req_we = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, vec_priority, exp_prio;
  logic [1:0] htrans = 2'h0, exp_top;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, instr_valid, alu_flags_we, branch_done, branch_taken;
  logic trap_nmi, ctx_restore, top_level_edge_select, top_level_irq_enable;
  nip_op_t instr_op;
  logic [3:0] req_op = 4'h0, req_flags = 4'h0, alu_flags;
  logic [7:0] req_cond = 8'h0, stack_cond, condition_code_reg, external_edge_select, exp_cond;
  logic [7:0] exp_ext;
  int n_errors = 0, checks_done = 0;

  always #20 core_clk = ~core_clk;

  nip_core_model u_core(.core_clk(core_clk), .nrst(nrst), .req(req), .req_op(req_op),
    .req_cond(req_cond), .req_we(req_we), .req_flags(req_flags), .instr_valid(instr_valid),
    .instr_op(instr_op), .stack_cond(stack_cond), .alu_flags_we(alu_flags_we),
    .alu_flags(alu_flags));

  nip_ctrl u_dut(.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .instr_valid(instr_valid),
    .instr_op(instr_op), .stack_cond(stack_cond), .alu_flags_we(alu_flags_we),
    .alu_flags(alu_flags), .condition_code_reg(condition_code_reg),
    .branch_done(branch_done), .branch_taken(branch_taken), .trap_nmi(trap_nmi),
    .ctx_restore(ctx_restore), .vec_priority(vec_priority),
    .external_edge_select(external_edge_select),
    .top_level_edge_select(top_level_edge_select),
    .top_level_irq_enable(top_level_irq_enable));

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // hreadyout is registered, so its value at the falling edge is what the next rise samples
  task automatic wait_rdy(output logic [31:0] rd);
    int n;
    n = 0;
    @(negedge core_clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(negedge core_clk);
    end
    if (n >= 50) begin
      n_errors++;
      summarize();
    end
    rd = hrdata;
    @(posedge core_clk);
  endtask

  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] d,
    output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_rdy(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy(rd);
  endtask

  function automatic logic [31:0] exp_reg(input logic [7:0] idx);
    case (idx)
      IDX_PRIO_BANK0, IDX_PRIO_BANK1, IDX_PRIO_BANK2, IDX_PRIO_BANK3:
        return {24'h0, exp_prio[8 * (idx - IDX_PRIO_BANK0) +: 8]};
      IDX_EXT_EDGE: return {24'h0, exp_ext};
      IDX_TOP_CTRL: return {30'h0, exp_top};
      IDX_COND_STATUS: return {24'h0, exp_cond};
      default: return 32'h0;
    endcase
  endfunction

  task automatic upd(input logic [7:0] idx, input logic [31:0] d);
    int k;
    logic [7:0] m;
    k = idx - IDX_PRIO_BANK0;
    if (k >= 0 && k < 4) begin
      m = PRIO_IMPL_MASK[8 * k +: 8];
      exp_prio[8 * k +: 8] = (d[7:0] & m) | ~m;
    end
    if (idx == IDX_EXT_EDGE) exp_ext = d[7:0];
    if (idx == IDX_TOP_CTRL) exp_top = d[1:0];
  endtask

  // Reads fresh values, writes random data, reads back; 0x2C is unmapped
  task automatic reg_test;
    logic [31:0] rd, d;
    for (int i = 8'h25; i <= 8'h2C; i++) begin
      ahb(1'b0, i[7:0], 32'h0, rd);
      chk(rd, exp_reg(i[7:0]));
      d = $urandom;
      ahb(1'b1, i[7:0], d, rd);
      upd(i[7:0], d);
      ahb(1'b0, i[7:0], 32'h0, rd);
      chk(rd, exp_reg(i[7:0]));
    end
    chk(vec_priority, exp_prio);
    chk({top_level_edge_select, top_level_irq_enable, external_edge_select, hresp},
      {exp_top, exp_ext, 1'b0});
    $display("test registers done");
  endtask

  task automatic do_reset;
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    exp_cond = COND_RST;
    exp_prio = PRIO_RST;
    exp_ext = EXT_EDGE_RST;
    exp_top = TOP_CTRL_RST;
    @(posedge core_clk);
  endtask

  function automatic logic [7:0] next_cond(input logic [3:0] op, input logic [7:0] s,
    input logic we, input logic [3:0] f);
    logic [7:0] c;
    c = exp_cond;
    if (we) c = {c[7:5], f[3], c[3], f[2:0]};
    case (op)
      NIP_OP_IRQ_EN, NIP_OP_HALT, NIP_OP_WAIT_IRQ: c = {c[7:6], 1'b1, c[4], 1'b0, c[2:0]};
      NIP_OP_IRQ_DIS, NIP_OP_TRAP: c = {c[7:6], 1'b1, c[4], 1'b1, c[2:0]};
      NIP_OP_POP_FLAGS, NIP_OP_IRQ_RET: c = s | COND_FIXED_ONES;
      default: ;
    endcase
    return c;
  endfunction

  task automatic do_op(input logic [3:0] op, input logic [7:0] s, input logic we,
    input logic [3:0] f);
    logic t;
    @(posedge core_clk);
    req <= 1'b1;
    req_op <= op;
    req_cond <= s;
    req_we <= we;
    req_flags <= f;
    @(posedge core_clk);
    req <= 1'b0;
    t = exp_cond[COND_I1_POS] & exp_cond[COND_I0_POS];
    exp_cond = next_cond(op, s, we, f);
    @(posedge core_clk);
    #1;
    chk(condition_code_reg, exp_cond);
    chk(branch_done, op == NIP_OP_BR_MASKED || op == NIP_OP_BR_UNMASKED);
    chk(branch_taken, op == NIP_OP_BR_MASKED ? t : op == NIP_OP_BR_UNMASKED ? !t : 1'b0);
    chk({trap_nmi, ctx_restore}, {op == NIP_OP_TRAP, op == NIP_OP_IRQ_RET});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(19406));
    do_reset;
    chk(condition_code_reg, exp_cond);
    reg_test;
    // Every code, refused ones too, from level 0 and from level 3
    for (int i = 0; i < 32; i++) begin
      do_op(i[0] ? NIP_OP_IRQ_EN : NIP_OP_IRQ_DIS, 8'h00, 1'b0, 4'h0);
      do_op(i[4:1], 8'hFF ^ i[7:0], i[1], i[3:0]);
    end
    $display("test instruction corners done");
    for (int i = 0; i < 300; i++) begin
      do_op(4'($urandom_range(0, 15)), 8'($urandom), 1'($urandom_range(0, 1)), 4'($urandom));
    end
    $display("test random instructions done");
    do_reset;
    reg_test;
    summarize();
  end
endmodule // tb
